// *** shared/pmseq_pkg.sv ***
package pmseq_pkg;
    // ****************************************
    // store geometry
    // ****************************************
    localparam int ADDR_W = 13;
    localparam int WORD_W = 16;
    localparam int DEPTH = 8192;
    localparam int OFFS_W = 11;
    localparam int PAGE_W = 2;
    localparam int PTR_W = 8;
    localparam int STACK_DEPTH = 6;
    localparam int SP_W = 3;
    localparam logic [ADDR_W-1:0] RESET_ADDR = 13'h0000;
    localparam logic [ADDR_W-1:0] GLYPH_BASE = 13'h1800;
    localparam logic [ADDR_W-1:0] TABLE_TOP = 13'h00FF;
    // ****************************************
    // interrupt vectors
    // ****************************************
    localparam logic [ADDR_W-1:0] VEC_REMOTE = 13'h0004;
    localparam logic [ADDR_W-1:0] VEC_TIMER = 13'h0003;
    localparam logic [ADDR_W-1:0] VEC_FRAME = 13'h0002;
    localparam logic [ADDR_W-1:0] VEC_SERIAL = 13'h0001;
    // ****************************************
    // flow operations
    // ****************************************
    typedef enum logic [3:0] {
        PMSEQ_OP_NEXT = 4'h0,
        PMSEQ_OP_JUMP = 4'h1,
        PMSEQ_OP_JUMP_PTR = 4'h2,
        PMSEQ_OP_CALL = 4'h3,
        PMSEQ_OP_CALL_PTR = 4'h4,
        PMSEQ_OP_RET = 4'h5,
        PMSEQ_OP_RET_SKIP = 4'h6,
        PMSEQ_OP_TABLE = 4'h7
    } pmseq_op_t;
    localparam logic [4:0] OPC_JUMP_P0 = 5'h0C;
    localparam logic [4:0] OPC_JUMP_P1 = 5'h0D;
    localparam logic [4:0] OPC_JUMP_P2 = 5'h0E;
    localparam logic [4:0] OPC_JUMP_P3 = 5'h0F;
    typedef enum logic [1:0] {
        PMSEQ_ST_FETCH = 2'b00,
        PMSEQ_ST_TABLE = 2'b01,
        PMSEQ_ST_RESTORE = 2'b10
    } pmseq_state_t;
endpackage

// *** verilog/pmseq_rom.sv ***
module pmseq_rom (
    // clock
    input wire logic clock,
    // read port
    input wire logic [pmseq_pkg::ADDR_W-1:0] addr,
    output logic [pmseq_pkg::WORD_W-1:0] data
);
    // read-only array, every word cleared to zero at start
    logic [pmseq_pkg::WORD_W-1:0] mem [0:pmseq_pkg::DEPTH-1];
    initial begin
        for (int i = 0; i < pmseq_pkg::DEPTH; i++) begin
            mem[i] = 16'h0000;
        end
    end
    always_ff @(posedge clock) begin
        data <= mem[addr];
    end
endmodule // pmseq_rom

// *** verilog/pmseq_stack.sv ***
module pmseq_stack (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // control
    input wire logic push,
    input wire logic pop,
    input wire logic [pmseq_pkg::ADDR_W-1:0] push_data,
    // state
    output logic [pmseq_pkg::ADDR_W-1:0] top,
    output logic [pmseq_pkg::SP_W-1:0] depth
);
    logic [pmseq_pkg::ADDR_W-1:0] slot [0:pmseq_pkg::STACK_DEPTH-1];
    logic [pmseq_pkg::SP_W-1:0] next_depth;
    assign next_depth = push ? depth + 3'h1 : (pop ? depth - 3'h1 : depth);
    assign top = (depth == 3'h0) ? 13'h0000 : slot[depth - 3'h1];
    always_ff @(posedge clock) begin
        if (srst) begin
            depth <= 3'h0;
        end else begin
            depth <= next_depth;
        end
    end
    always_ff @(posedge clock) begin
        if (push && depth < 3'(pmseq_pkg::STACK_DEPTH)) begin
            slot[depth] <= push_data;
        end
    end
endmodule // pmseq_stack

// *** verilog/pmseq_top.sv ***
module pmseq_top (
    // clock and reset
    input wire logic CLOCK,
    input wire logic SRST,
    // instruction from execute logic
    input wire logic STEP,
    input wire pmseq_pkg::pmseq_op_t OP,
    input wire logic [4:0] OPCODE,
    input wire logic [pmseq_pkg::OFFS_W-1:0] OPERAND,
    input wire logic [pmseq_pkg::PTR_W-1:0] POINTER_REGISTER,
    // interrupt requests
    input wire logic IRQ_REMOTE,
    input wire logic IRQ_TIMER,
    input wire logic IRQ_FRAME,
    input wire logic IRQ_SERIAL,
    // glyph port
    input wire logic [pmseq_pkg::OFFS_W-1:0] GLYPH_ADDR,
    output logic [pmseq_pkg::WORD_W-1:0] GLYPH_DATA,
    // fetch outputs
    output logic [pmseq_pkg::ADDR_W-1:0] PROGRAM_COUNTER,
    output logic [pmseq_pkg::WORD_W-1:0] INSTR,
    output logic INSTR_NOP,
    output logic BUSY,
    // table read result and stack depth
    output logic [pmseq_pkg::WORD_W-1:0] DATA_BUFFER,
    output logic DATA_BUFFER_VALID,
    output logic [pmseq_pkg::SP_W-1:0] STACK_DEPTH
);
    // ****************************************
    // state
    // ****************************************
    pmseq_pkg::pmseq_state_t state;
    pmseq_pkg::pmseq_state_t next_state;
    logic [pmseq_pkg::ADDR_W-1:0] pc;
    logic [pmseq_pkg::ADDR_W-1:0] next_pc;
    logic skip_pending;
    logic [pmseq_pkg::WORD_W-1:0] rom_data;
    logic [pmseq_pkg::WORD_W-1:0] glyph_word;
    logic [pmseq_pkg::ADDR_W-1:0] stack_top;
    logic [pmseq_pkg::SP_W-1:0] depth;

    // ****************************************
    // decode
    // ****************************************
    function automatic logic [pmseq_pkg::ADDR_W-1:0] ptr_addr(
        input logic [pmseq_pkg::PTR_W-1:0] p);
        ptr_addr = {5'h00, p};
    endfunction

    wire fetching = (state == pmseq_pkg::PMSEQ_ST_FETCH);
    wire irq_any = IRQ_REMOTE | IRQ_TIMER | IRQ_FRAME | IRQ_SERIAL;
    wire take_irq = fetching && STEP && irq_any;
    wire take_op = fetching && STEP && !irq_any;
    wire [pmseq_pkg::ADDR_W-1:0] pc_inc = pc + 13'h0001;
    wire [pmseq_pkg::ADDR_W-1:0] irq_vec =
        IRQ_REMOTE ? pmseq_pkg::VEC_REMOTE :
        IRQ_TIMER ? pmseq_pkg::VEC_TIMER :
        IRQ_FRAME ? pmseq_pkg::VEC_FRAME : pmseq_pkg::VEC_SERIAL;
    wire [pmseq_pkg::PAGE_W-1:0] jump_page = OPCODE[1:0]; // 0CH->0, 0DH->1
    wire [pmseq_pkg::ADDR_W-1:0] jump_target = {jump_page, OPERAND};
    wire [pmseq_pkg::ADDR_W-1:0] call_target = {2'b00, OPERAND};
    wire is_op = take_op;
    wire op_call = is_op && (OP == pmseq_pkg::PMSEQ_OP_CALL || OP == pmseq_pkg::PMSEQ_OP_CALL_PTR);
    wire op_ret = is_op && (OP == pmseq_pkg::PMSEQ_OP_RET || OP == pmseq_pkg::PMSEQ_OP_RET_SKIP);
    wire op_table = is_op && OP == pmseq_pkg::PMSEQ_OP_TABLE;
    wire stack_push = op_call || take_irq || op_table;
    wire stack_pop = op_ret || (state == pmseq_pkg::PMSEQ_ST_RESTORE);
    wire [pmseq_pkg::ADDR_W-1:0] push_value = op_table ? pc : pc_inc;
    // rom read address: table read reuses the port while the counter waits
    wire [pmseq_pkg::ADDR_W-1:0] rom_addr =
        (op_table) ? ptr_addr(POINTER_REGISTER) : next_pc;
    // glyph reads always land inside the upper area of the glyph copy
    wire [pmseq_pkg::ADDR_W-1:0] glyph_rom_addr =
        pmseq_pkg::GLYPH_BASE | {2'b00, GLYPH_ADDR};

    always_comb begin
        next_pc = pc;
        next_state = state;
        case (state)
            pmseq_pkg::PMSEQ_ST_FETCH: begin
                if (take_irq) begin
                    next_pc = irq_vec;
                end else if (take_op) begin
                    case (OP)
                        pmseq_pkg::PMSEQ_OP_JUMP: next_pc = jump_target;
                        pmseq_pkg::PMSEQ_OP_JUMP_PTR: next_pc = ptr_addr(POINTER_REGISTER);
                        pmseq_pkg::PMSEQ_OP_CALL: next_pc = call_target;
                        pmseq_pkg::PMSEQ_OP_CALL_PTR: next_pc = ptr_addr(POINTER_REGISTER);
                        pmseq_pkg::PMSEQ_OP_RET: next_pc = stack_top;
                        pmseq_pkg::PMSEQ_OP_RET_SKIP: next_pc = stack_top;
                        pmseq_pkg::PMSEQ_OP_TABLE: begin
                            next_state = pmseq_pkg::PMSEQ_ST_TABLE;
                        end
                        default: next_pc = pc_inc;
                    endcase
                end
            end
            pmseq_pkg::PMSEQ_ST_TABLE: begin
                next_state = pmseq_pkg::PMSEQ_ST_RESTORE;
            end
            pmseq_pkg::PMSEQ_ST_RESTORE: begin
                next_pc = stack_top + 13'h0001; // pop saved address
                next_state = pmseq_pkg::PMSEQ_ST_FETCH;
            end
            default: next_state = pmseq_pkg::PMSEQ_ST_FETCH;
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            pc <= pmseq_pkg::RESET_ADDR;
            state <= pmseq_pkg::PMSEQ_ST_FETCH;
        end else begin
            pc <= next_pc;
            state <= next_state;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            skip_pending <= 1'b0;
        end else if (take_op || take_irq) begin
            skip_pending <= op_ret && OP == pmseq_pkg::PMSEQ_OP_RET_SKIP;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            DATA_BUFFER <= 16'h0000;
            DATA_BUFFER_VALID <= 1'b0;
        end else begin
            DATA_BUFFER_VALID <= (state == pmseq_pkg::PMSEQ_ST_TABLE);
            if (state == pmseq_pkg::PMSEQ_ST_TABLE) begin
                DATA_BUFFER <= rom_data; // whole 16-bit word loaded at once
            end
        end
    end

    // ****************************************
    // store and stack
    // ****************************************
    // single read port, no write path
    pmseq_rom u_rom (
        .clock(CLOCK),
        .addr(rom_addr),
        .data(rom_data)
    );

    // glyph area read from a separate second copy of the store at 1800H..1FFFH
    pmseq_rom u_glyph (
        .clock(CLOCK),
        .addr(glyph_rom_addr),
        .data(glyph_word)
    );

    pmseq_stack u_stack (
        .clock(CLOCK),
        .srst(SRST),
        .push(stack_push),
        .pop(stack_pop),
        .push_data(push_value),
        .top(stack_top),
        .depth(depth)
    );

    assign PROGRAM_COUNTER = pc;
    assign INSTR = rom_data;
    assign INSTR_NOP = skip_pending;
    assign BUSY = !fetching;
    assign GLYPH_DATA = glyph_word;
    assign STACK_DEPTH = depth;

    // ****************************************
    // checks
    // ****************************************
    sequence s_table_start;
        take_op && OP == pmseq_pkg::PMSEQ_OP_TABLE;
    endsequence

    // two blocked cycles, buffer loaded in the second
    sequence s_table_busy;
        BUSY ##1 (BUSY && DATA_BUFFER_VALID);
    endsequence

    sequence s_call_start;
        take_op && (OP == pmseq_pkg::PMSEQ_OP_CALL || OP == pmseq_pkg::PMSEQ_OP_CALL_PTR);
    endsequence

    sequence s_ret_start;
        take_op && (OP == pmseq_pkg::PMSEQ_OP_RET || OP == pmseq_pkg::PMSEQ_OP_RET_SKIP);
    endsequence

    AST_RESET_PC: assert property (@(posedge CLOCK) SRST |=> pc == 13'h0000)
        else $error("pc not cleared by reset");
    AST_SEQ: assert property (@(posedge CLOCK) disable iff (SRST)
        take_op && OP == pmseq_pkg::PMSEQ_OP_NEXT |=> pc == $past(pc) + 13'h0001)
        else $error("sequential step wrong");
    AST_IRQ_VEC: assert property (@(posedge CLOCK) disable iff (SRST)
        take_irq && IRQ_REMOTE |=> pc == 13'h0004)
        else $error("remote vector wrong");
    AST_JUMP: assert property (@(posedge CLOCK) disable iff (SRST)
        take_op && OP == pmseq_pkg::PMSEQ_OP_JUMP && OPCODE == pmseq_pkg::OPC_JUMP_P1
        |=> pc[12:11] == 2'b01)
        else $error("jump page wrong");
    AST_PTR_RANGE: assert property (@(posedge CLOCK) disable iff (SRST)
        take_op && (OP == pmseq_pkg::PMSEQ_OP_JUMP_PTR || OP == pmseq_pkg::PMSEQ_OP_CALL_PTR)
        |=> pc <= pmseq_pkg::TABLE_TOP)
        else $error("pointer target out of table region");
    AST_CALL_PAGE0: assert property (@(posedge CLOCK) disable iff (SRST)
        take_op && OP == pmseq_pkg::PMSEQ_OP_CALL |=> pc[12:11] == 2'b00)
        else $error("call left page 0");
    AST_CALL_RET: assert property (@(posedge CLOCK) disable iff (SRST)
        take_op && OP == pmseq_pkg::PMSEQ_OP_CALL && depth < 3'h6
        |=> stack_top == $past(pc) + 13'h0001)
        else $error("return address wrong");
    AST_SKIP: assert property (@(posedge CLOCK) disable iff (SRST)
        take_op && OP == pmseq_pkg::PMSEQ_OP_RET_SKIP |=> INSTR_NOP)
        else $error("skip not flagged");
    AST_TABLE: assert property (@(posedge CLOCK) disable iff (SRST)
        s_table_start |=> s_table_busy ##1 (!BUSY
        && pc == $past(pc, 3) + 13'h0001))
        else $error("table read sequence wrong");

    // ****************************************
    // target and depth checks
    // ****************************************
    AST_JUMP_TARGET: assert property (@(posedge CLOCK) disable iff (SRST)
        take_op && OP == pmseq_pkg::PMSEQ_OP_JUMP
        |=> pc == {$past(OPCODE[1:0]), $past(OPERAND)})
        else $error("jump target wrong");

    AST_JUMP_P0: assert property (@(posedge CLOCK) disable iff (SRST)
        take_op && OP == pmseq_pkg::PMSEQ_OP_JUMP && OPCODE == pmseq_pkg::OPC_JUMP_P0
        |=> pc[12:11] == 2'b00)
        else $error("page 0 jump wrong");

    AST_JUMP_PTR: assert property (@(posedge CLOCK) disable iff (SRST)
        take_op && OP == pmseq_pkg::PMSEQ_OP_JUMP_PTR
        |=> pc == {5'h00, $past(POINTER_REGISTER)})
        else $error("pointer jump target wrong");

    AST_CALL_PTR: assert property (@(posedge CLOCK) disable iff (SRST)
        take_op && OP == pmseq_pkg::PMSEQ_OP_CALL_PTR
        |=> pc == {5'h00, $past(POINTER_REGISTER)})
        else $error("pointer call target wrong");

    AST_RET_TARGET: assert property (@(posedge CLOCK) disable iff (SRST)
        s_ret_start and depth != 3'h0
        |=> pc == $past(stack_top))
        else $error("return target wrong");

    AST_CALL_DEPTH: assert property (@(posedge CLOCK) disable iff (SRST)
        s_call_start and depth < 3'h6
        |=> depth == $past(depth) + 3'h1)
        else $error("call did not push");

    AST_RET_DEPTH: assert property (@(posedge CLOCK) disable iff (SRST)
        s_ret_start and depth != 3'h0
        |=> depth == $past(depth) - 3'h1)
        else $error("return did not pop");

    // ****************************************
    // interrupt checks
    // ****************************************
    AST_IRQ_RANGE: assert property (@(posedge CLOCK) disable iff (SRST)
        take_irq |=> pc >= pmseq_pkg::VEC_SERIAL && pc <= pmseq_pkg::VEC_REMOTE)
        else $error("interrupt left header area");

    AST_IRQ_TIMER: assert property (@(posedge CLOCK) disable iff (SRST)
        take_irq && !IRQ_REMOTE && IRQ_TIMER
        |=> pc == pmseq_pkg::VEC_TIMER)
        else $error("timer vector wrong");

    AST_IRQ_SERIAL: assert property (@(posedge CLOCK) disable iff (SRST)
        take_irq && !IRQ_REMOTE && !IRQ_TIMER && !IRQ_FRAME
        |=> pc == pmseq_pkg::VEC_SERIAL)
        else $error("serial vector wrong");

    AST_IRQ_PUSH: assert property (@(posedge CLOCK) disable iff (SRST)
        take_irq && depth < 3'h6
        |=> stack_top == $past(pc) + 13'h0001)
        else $error("interrupt return address wrong");

    // ****************************************
    // table, skip, glyph and reset checks
    // ****************************************
    AST_TABLE_ADDR: assert property (@(posedge CLOCK) disable iff (SRST)
        op_table |-> rom_addr <= pmseq_pkg::TABLE_TOP)
        else $error("table read outside table region");

    AST_TABLE_DEPTH: assert property (@(posedge CLOCK) disable iff (SRST)
        s_table_start and depth < 3'h6
        |=> depth == $past(depth) + 3'h1 ##2 depth == $past(depth, 3))
        else $error("table read stack use wrong");

    AST_TABLE_HOLD: assert property (@(posedge CLOCK) disable iff (SRST)
        state == pmseq_pkg::PMSEQ_ST_TABLE |=> pc == $past(pc))
        else $error("counter moved during table read");

    AST_BUF_STABLE: assert property (@(posedge CLOCK) disable iff (SRST)
        $changed(DATA_BUFFER) |-> DATA_BUFFER_VALID)
        else $error("data buffer changed outside table read");

    AST_NOP_CLEAR: assert property (@(posedge CLOCK) disable iff (SRST)
        INSTR_NOP && take_op && OP != pmseq_pkg::PMSEQ_OP_RET_SKIP
        |=> !INSTR_NOP)
        else $error("skip flag stuck");

    AST_GLYPH_AREA: assert property (@(posedge CLOCK) disable iff (SRST)
        glyph_rom_addr >= pmseq_pkg::GLYPH_BASE)
        else $error("glyph read below glyph area");

    AST_RESET_IDLE: assert property (@(posedge CLOCK)
        SRST |=> !BUSY && depth == 3'h0 && !DATA_BUFFER_VALID)
        else $error("not idle after reset");
endmodule // pmseq_top

// *** verification/pmseq_exec_model.sv ***
module pmseq_exec_model (
    // clock
    input wire logic clock,
    // instruction toward sequencer
    output logic step,
    output pmseq_pkg::pmseq_op_t op,
    output logic [4:0] opcode,
    output logic [pmseq_pkg::OFFS_W-1:0] operand,
    output logic [pmseq_pkg::PTR_W-1:0] pointer,
    output logic [3:0] irq
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        step = 1'b0;
        op = pmseq_pkg::PMSEQ_OP_NEXT;
        opcode = 5'h00;
        operand = 11'h000;
        pointer = 8'h00;
        irq = 4'h0;
    end
    // one finishing instruction, held for one take edge
    task automatic issue(input pmseq_pkg::pmseq_op_t o, input logic [4:0] oc,
        input logic [10:0] od, input logic [7:0] p, input logic [3:0] rq);
        @(posedge clock);
        step <= 1'b1;
        op <= o;
        opcode <= oc;
        operand <= od;
        pointer <= p;
        irq <= rq;
        @(posedge clock);
        // released opcode, operand and pointer no longer show the old value
        step <= 1'b0;
        irq <= 4'h0;
        opcode <= ~oc;
        operand <= ~od;
        pointer <= ~p;
    endtask
endmodule // pmseq_exec_model

// *** verification/testbench.sv ***
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // signals
    // ****************************************
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [10:0] glyph_addr = 11'h000;
    logic step, busy, instr_nop, dbv;
    pmseq_pkg::pmseq_op_t op;
    logic [4:0] opcode;
    logic [10:0] operand;
    logic [7:0] pointer;
    logic [3:0] irq;
    logic [15:0] glyph_data, instr, dbuf;
    logic [12:0] pc, epc, ret;
    logic [2:0] depth;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    always #12.5 clock = ~clock;
    pmseq_exec_model u_exec (.clock(clock), .step(step), .op(op), .opcode(opcode),
        .operand(operand), .pointer(pointer), .irq(irq));
    pmseq_top dut (.CLOCK(clock), .SRST(srst), .STEP(step), .OP(op), .OPCODE(opcode),
        .OPERAND(operand), .POINTER_REGISTER(pointer), .IRQ_REMOTE(irq[3]),
        .IRQ_TIMER(irq[2]), .IRQ_FRAME(irq[1]), .IRQ_SERIAL(irq[0]),
        .GLYPH_ADDR(glyph_addr), .GLYPH_DATA(glyph_data), .PROGRAM_COUNTER(pc),
        .INSTR(instr), .INSTR_NOP(instr_nop), .BUSY(busy), .DATA_BUFFER(dbuf),
        .DATA_BUFFER_VALID(dbv), .STACK_DEPTH(depth));
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [12:0] f_vec(input logic [3:0] r);
        if (r[3]) return pmseq_pkg::VEC_REMOTE;
        if (r[2]) return pmseq_pkg::VEC_TIMER;
        if (r[1]) return pmseq_pkg::VEC_FRAME;
        return pmseq_pkg::VEC_SERIAL;
    endfunction
    // distinct, address-dependent store contents
    function automatic logic [15:0] f_word(input logic [12:0] a);
        return {a[2:0], a} ^ 16'hC3A5;
    endfunction
    task automatic tally_and_finish();
        if (errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic op_chk(input pmseq_pkg::pmseq_op_t o, input logic [4:0] oc,
        input logic [10:0] od, input logic [7:0] p, input logic [3:0] rq,
        input logic [12:0] ex, input logic [2:0] ed);
        u_exec.issue(o, oc, od, p, rq);
        #1;
        `CHK("program_counter", ex, pc)
        `CHK("stack_depth", ed, depth)
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            tally_and_finish();
        end
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        logic [10:0] od;
        logic [7:0] p;
        void'($urandom(32'h3e9c7113));
        repeat (16) @(posedge clock);
        for (int a = 0; a < pmseq_pkg::DEPTH; a++) begin
            dut.u_rom.mem[a] = f_word(13'(a));
            dut.u_glyph.mem[a] = f_word(13'(a));
        end
        srst <= 1'b0;
        #1;
        `CHK("pc_reset", 13'h0000, pc)
        `CHK("busy_reset", 1'b0, busy)
        for (int i = 1; i <= 4; i++) op_chk(pmseq_pkg::PMSEQ_OP_NEXT, 5'h00, 11'h000, 8'h00,
            4'h0, 13'(i), 3'h0);
        for (int k = 0; k < 8; k++) begin
            od = (k == 1) ? 11'h000 : 11'($urandom);
            op_chk(pmseq_pkg::PMSEQ_OP_JUMP, 5'h0C + 5'(k % 4), od, 8'h00, 4'h0,
                {2'(k % 4), od}, 3'h0);
        end
        for (int k = 0; k < 3; k++) begin
            p = (k == 0) ? 8'hFF : 8'($urandom);
            op_chk(pmseq_pkg::PMSEQ_OP_JUMP_PTR, 5'h00, 11'h000, p, 4'h0, {5'h00, p},
                3'h0);
        end
        for (int k = 0; k < 2; k++) begin
            od = 11'($urandom);
            p = 8'($urandom);
            op_chk(pmseq_pkg::PMSEQ_OP_JUMP, 5'h0E + 5'(k), od, 8'h00, 4'h0,
                {2'(2 + k), od}, 3'h0);
            ret = {2'(2 + k), od} + 13'h0001;
            epc = (k == 0) ? {2'b00, ~od} : {5'h00, p};
            op_chk((k == 0) ? pmseq_pkg::PMSEQ_OP_CALL : pmseq_pkg::PMSEQ_OP_CALL_PTR,
                5'h00, ~od, p, 4'h0, epc, 3'h1);
            op_chk((k == 0) ? pmseq_pkg::PMSEQ_OP_RET : pmseq_pkg::PMSEQ_OP_RET_SKIP,
                5'h00, 11'h000, 8'h00, 4'h0, ret, 3'h0);
            `CHK("instr_nop", 1'(k), instr_nop)
        end
        op_chk(pmseq_pkg::PMSEQ_OP_NEXT, 5'h00, 11'h000, 8'h00, 4'h0, ret + 13'h0001,
            3'h0);
        `CHK("instr_nop_clear", 1'b0, instr_nop)
        for (int r = 1; r < 16; r++) begin
            ret = pc + 13'h0001;
            op_chk(pmseq_pkg::PMSEQ_OP_NEXT, 5'h00, 11'h000, 8'h00, 4'(r), f_vec(4'(r)),
                3'h1);
            op_chk(pmseq_pkg::PMSEQ_OP_RET, 5'h00, 11'h000, 8'h00, 4'h0, ret, 3'h0);
        end
        for (int k = 0; k < 3; k++) begin
            epc = pc + 13'h0001;
            p = (k == 0) ? 8'hFF : 8'($urandom);
            op_chk(pmseq_pkg::PMSEQ_OP_TABLE, 5'h00, 11'h000, p, 4'h0, pc, 3'h1);
            `CHK("busy_c1", 1'b1, busy)
            @(posedge clock);
            #1;
            `CHK("busy_c2", 1'b1, busy)
            `CHK("buffer_valid", 1'b1, dbv)
            `CHK("data_buffer", f_word({5'h00, p}), dbuf)
            @(posedge clock);
            #1;
            `CHK("busy_c3", 1'b0, busy)
            `CHK("buffer_valid_end", 1'b0, dbv)
            `CHK("data_buffer_hold", f_word({5'h00, p}), dbuf)
            `CHK("pc_table", epc, pc)
            `CHK("depth_table", 3'h0, depth)
        end
        od = 11'($urandom);
        glyph_addr <= od;
        repeat (2) @(posedge clock);
        #1;
        `CHK("glyph_data", f_word(pmseq_pkg::GLYPH_BASE | {2'b00, od}), glyph_data)
        `CHK("instr", f_word(pc), instr)
        @(posedge clock);
        srst <= 1'b1;
        @(posedge clock);
        srst <= 1'b0;
        #1;
        `CHK("pc_rereset", 13'h0000, pc)
        tally_and_finish();
    end
endmodule // testbench
